// ### core/rio_consts.vh
// Purpose: constants of the rtc interrupt and clock output block
// Assumes: register index is a 4-bit word address on the register port
// Notes:   times are kept in their own unit, counts derived from them
`ifndef RIO_CONSTS_VH
`define RIO_CONSTS_VH

// ***********************************************
// register offsets
// ***********************************************
`define RIO_OFS_CTRL        4'hE
`define RIO_OFS_FLAG        4'hF

// ***********************************************
// control register fields (offset E)
// ***********************************************
`define RIO_BIT_FIRST_EN    7
`define RIO_BIT_SECOND_EN   6
`define RIO_BIT_ROUTE_HI    5
`define RIO_BIT_ROUTE_LO    4
`define RIO_CYC_MSB         2
`define RIO_CYC_LSB         0
`define RIO_CTRL_RESET      8'h00

// ***********************************************
// flag register fields (offset F)
// ***********************************************
`define RIO_BIT_SECOND_FLG  0
`define RIO_BIT_FIRST_FLG   1
`define RIO_BIT_PER_FLG     2
`define RIO_BIT_CLK_INH     3
`define RIO_BIT_HALT        4

// ***********************************************
// periodic cycle codes
// ***********************************************
`define RIO_CYC_OFF         3'h0
`define RIO_CYC_FIXED       3'h1
`define RIO_CYC_2HZ         3'h2
`define RIO_CYC_1HZ         3'h3
`define RIO_CYC_SEC         3'h4
`define RIO_CYC_MIN         3'h5
`define RIO_CYC_HOUR        3'h6
`define RIO_CYC_MONTH       3'h7

// ***********************************************
// pulse timing, counted in oscillator edges
// ***********************************************
`define RIO_XTAL_A_HZ       32768
`define RIO_XTAL_B_HZ       32000
`define RIO_LAG_A_US        92
`define RIO_LAG_B_US        94
`define RIO_LAG_A  ((`RIO_LAG_A_US * `RIO_XTAL_A_HZ) / 1000000)
`define RIO_LAG_B  ((`RIO_LAG_B_US * `RIO_XTAL_B_HZ) / 1000000)
`define RIO_HALF_A_MS       500
`define RIO_HALF_B_MS       496
`define RIO_HALF_A ((`RIO_HALF_A_MS * `RIO_XTAL_A_HZ) / 1000)
`define RIO_HALF_B ((`RIO_HALF_B_MS * `RIO_XTAL_B_HZ) / 1000)
`define RIO_QTR_A_US        250000
`define RIO_QTR_B1_US       248000
`define RIO_QTR_B2_US       252000
`define RIO_QTR_A  ((`RIO_QTR_A_US * `RIO_XTAL_A_HZ) / 1000000)
`define RIO_QTR_B1 ((`RIO_QTR_B1_US / 1000 * `RIO_XTAL_B_HZ) / 1000)
`define RIO_QTR_B2 ((`RIO_QTR_B2_US / 1000 * `RIO_XTAL_B_HZ) / 1000)
`define RIO_SUB_W           15

`endif

// ### core/rio_pin_mux.v
// Purpose: routes active sources onto open-drain output pins
// Assumes: inputs are active-high requests, already resolved per source
// Notes:   pins only pull low; pull-up is outside
`timescale 1ns/1ps
`include "rio_consts.vh"

module rio_pin_mux #(
  parameter SINGLE_PIN = 0
) (
  ref_clk,
  rst_b,
  first_act,
  second_act,
  periodic_act,
  clock_low,
  route_sel,
  irq_out_first_oe,
  irq_out_second_oe,
  irq_out_single_oe,
  osc_clock_pin_oe
);
  input  wire       ref_clk;
  input  wire       rst_b;
  input  wire       first_act;
  input  wire       second_act;
  input  wire       periodic_act;
  input  wire       clock_low;
  input  wire [1:0] route_sel;
  output reg        irq_out_first_oe;
  output reg        irq_out_second_oe;
  output reg        irq_out_single_oe;
  output reg        osc_clock_pin_oe;

  // ***********************************************
  // route decode
  // ***********************************************
  // second alarm uses the low select bit, periodic the high one
  function to_pin_b;
    input [1:0] sel;
    input       use_hi;
    begin
      to_pin_b = use_hi ? sel[1] : sel[0]; // R1
    end
  endfunction

  wire sec_b = to_pin_b(route_sel, 1'b0);
  wire per_b = to_pin_b(route_sel, 1'b1);

  wire nxt_a;
  wire nxt_b;
  wire nxt_s;
  assign nxt_a = first_act | (second_act & ~sec_b)
               | (periodic_act & ~per_b); // R1 R8
  assign nxt_b = (second_act & sec_b) | (periodic_act & per_b)
               | clock_low; // R5 R8
  assign nxt_s = first_act | second_act | periodic_act; // R19

  // ***********************************************
  // registered enables
  // ***********************************************
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_out_first_oe  <= 1'b0;
      irq_out_second_oe <= 1'b0;
      irq_out_single_oe <= 1'b0;
      osc_clock_pin_oe  <= 1'b0;
    end else begin
      // unused variant pins stay released
      irq_out_first_oe  <= (SINGLE_PIN == 0) ? nxt_a : 1'b0;
      irq_out_second_oe <= (SINGLE_PIN == 0) ? nxt_b : 1'b0;
      irq_out_single_oe <= (SINGLE_PIN != 0) ? nxt_s : 1'b0; // R19
      osc_clock_pin_oe  <= (SINGLE_PIN != 0) ? clock_low : 1'b0; // R5
    end
  end

endmodule // rio_pin_mux

// ### core/rio_irq_ctl.v
// Purpose: alarm, periodic and 32 kHz output control of a serial rtc
// Assumes: tick_sec is the trimmed seconds increment, one cycle wide
// Notes:   oscillator is sampled as a synchronous level on ref_clk
//
// Contract
// R1 - select field routes second alarm and periodic to pin A or B
// R2 - first alarm flag at F bit 1, enable at E bit 7
// R3 - second alarm flag at F bit 0, enable at E bit 6
// R4 - periodic flag at F bit 2; cycle field E[2:0], zero disables
// R5 - 32 kHz on pin B or clock pin; inhibit bit F[3] releases it
// R6 - after power-on halt flag, enables, cycle, inhibit, select are zero; code resets the halt flag to 1
// R7 - right after power-on the clock appears on pin B
// R8 - sources sharing a pin form an or of active-low waveforms
// R9 - host reads the flag register to find the active source
// R10 - host loads alarm time with enable off; match then pulls low
// R11 - alarm output is enable and flag; flag reads 1 while low
// R12 - code 001 fixed low; 010 2 Hz; 011 1 Hz, half duty
// R13 - level codes: every second, minute, hour, month start
// R14 - level mode falls together with the seconds increment
// R15 - pulse mode falls about 92 or 94 us after the increment
// R16 - 32.000 kHz crystal gives 0.496 and 0.504 s periods
// R17 - trimming perturbs periodic timing every 20 seconds
// R18 - clock output passes the raw oscillator unchanged
// R19 - single-pin variant drives all interrupts to one pin
// R20 - while halt flag is set, control bits are held at zero
// R21 - level interrupt stays until host writes 0 to the flag
// R22 - writing 0 to an alarm flag releases its output
// R23 - outputs are open-drain: pull low when on, released when off
`timescale 1ns/1ps
`include "rio_consts.vh"

module rio_irq_ctl #(
  parameter SINGLE_PIN = 0
) (
  ref_clk,
  rst_b,
  osc_clk,
  xtal_32000,
  tick_sec,
  at_minute_top,
  at_hour_top,
  at_month_top,
  first_alarm_match,
  second_alarm_match,
  osc_halt_detect,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rdata,
  irq_out_first_o,
  irq_out_first_oe,
  irq_out_second_o,
  irq_out_second_oe,
  irq_out_single_o,
  irq_out_single_oe,
  osc_clock_pin_o,
  osc_clock_pin_oe
);
  input  wire       ref_clk;
  input  wire       rst_b;
  input  wire       osc_clk;
  input  wire       xtal_32000;
  input  wire       tick_sec;
  input  wire       at_minute_top;
  input  wire       at_hour_top;
  input  wire       at_month_top;
  input  wire       first_alarm_match;
  input  wire       second_alarm_match;
  input  wire       osc_halt_detect;
  input  wire [3:0] reg_addr;
  input  wire [7:0] reg_wdata;
  input  wire       reg_wr;
  output reg  [7:0] reg_rdata;
  output wire       irq_out_first_o;
  output wire       irq_out_first_oe;
  output wire       irq_out_second_o;
  output wire       irq_out_second_oe;
  output wire       irq_out_single_o;
  output wire       irq_out_single_oe;
  output wire       osc_clock_pin_o;
  output wire       osc_clock_pin_oe;

  localparam SW = `RIO_SUB_W;
  localparam integer LAG_A  = `RIO_LAG_A;
  localparam integer LAG_B  = `RIO_LAG_B;
  localparam integer HALF_A = `RIO_HALF_A;
  localparam integer HALF_B = `RIO_HALF_B;
  localparam integer QTR_A  = `RIO_QTR_A;
  localparam integer QTR_B1 = `RIO_QTR_B1;
  localparam integer QTR_B2 = `RIO_QTR_B2;

  // ***********************************************
  // register state
  // ***********************************************
  reg  [7:0]    ctrl_ff;
  reg  [7:0]    nxt_ctrl;
  reg           first_flg_ff;
  reg           second_flg_ff;
  reg           per_flg_ff;
  reg           clk_inh_ff;
  reg           halt_ff;
  reg           nxt_first_flg;
  reg           nxt_second_flg;
  reg           nxt_per_flg;
  reg           nxt_clk_inh;
  reg           nxt_halt;
  reg  [7:0]    nxt_rdata;

  // ***********************************************
  // oscillator edge and sub-second counter
  // ***********************************************
  reg           osc_d_ff;
  reg  [SW-1:0] sub_ff;
  reg  [SW-1:0] nxt_sub;
  wire          osc_rise;

  wire          wr_ctrl;
  wire          wr_flag;
  wire          first_en;
  wire          second_en;
  wire [2:0]    cyc_sel;
  wire [1:0]    route_sel;
  wire          level_mode;
  reg           level_evt;
  reg           pulse_low;

  wire [SW-1:0] lag;
  wire [SW-1:0] half;
  wire [SW-1:0] qtr1;
  wire [SW-1:0] qtr2;

  wire          first_act;
  wire          second_act;
  wire          periodic_act;
  wire          clock_low;

  assign wr_ctrl    = reg_wr & (reg_addr == `RIO_OFS_CTRL);
  assign wr_flag    = reg_wr & (reg_addr == `RIO_OFS_FLAG);
  assign first_en   = ctrl_ff[`RIO_BIT_FIRST_EN]; // R2
  assign second_en  = ctrl_ff[`RIO_BIT_SECOND_EN]; // R3
  assign cyc_sel    = ctrl_ff[`RIO_CYC_MSB:`RIO_CYC_LSB]; // R4
  assign route_sel  = {ctrl_ff[`RIO_BIT_ROUTE_HI],
                       ctrl_ff[`RIO_BIT_ROUTE_LO]};
  assign level_mode = cyc_sel[2];
  assign osc_rise   = osc_clk & ~osc_d_ff;

  // crystal choice sets the lag and the low windows
  assign lag  = xtal_32000 ? LAG_B[SW-1:0]  : LAG_A[SW-1:0]; // R15
  assign half = xtal_32000 ? HALF_B[SW-1:0] : HALF_A[SW-1:0]; // R16
  assign qtr1 = xtal_32000 ? QTR_B1[SW-1:0] : QTR_A[SW-1:0]; // R16
  assign qtr2 = xtal_32000 ? QTR_B2[SW-1:0] : QTR_A[SW-1:0]; // R16

  // ***********************************************
  // sub-second count
  // ***********************************************
  // restarts on the trimmed tick, so trim shifts land here
  always @* begin
    nxt_sub = sub_ff;
    if (tick_sec) begin
      nxt_sub = {SW{1'b0}}; // R17
    end else if (osc_rise && (sub_ff != {SW{1'b1}})) begin
      nxt_sub = sub_ff + {{(SW-1){1'b0}}, 1'b1};
    end
  end

  // ***********************************************
  // pulse and level sources
  // ***********************************************
  always @* begin
    pulse_low = 1'b0;
    case (cyc_sel)
      `RIO_CYC_FIXED: begin
        pulse_low = 1'b1; // R12
      end
      `RIO_CYC_2HZ: begin
        // two windows per second, second one after the first half
        pulse_low = ((sub_ff >= lag) && (sub_ff < lag + qtr1)) ||
                    ((sub_ff >= lag + half) &&
                     (sub_ff < lag + half + qtr2)); // R12 R15 R16
      end
      `RIO_CYC_1HZ: begin
        pulse_low = (sub_ff >= lag) && (sub_ff < lag + half); // R12 R16
      end
      default: begin
        pulse_low = 1'b0;
      end
    endcase
  end

  always @* begin
    level_evt = 1'b0;
    case (cyc_sel)
      `RIO_CYC_SEC: begin
        level_evt = tick_sec; // R13 R14
      end
      `RIO_CYC_MIN: begin
        level_evt = tick_sec & at_minute_top; // R13
      end
      `RIO_CYC_HOUR: begin
        level_evt = tick_sec & at_hour_top; // R13
      end
      `RIO_CYC_MONTH: begin
        level_evt = tick_sec & at_month_top; // R13
      end
      default: begin
        level_evt = 1'b0;
      end
    endcase
  end

  // ***********************************************
  // register next state
  // ***********************************************
  always @* begin
    nxt_ctrl       = ctrl_ff;
    nxt_first_flg  = first_flg_ff;
    nxt_second_flg = second_flg_ff;
    nxt_per_flg    = per_flg_ff;
    nxt_clk_inh    = clk_inh_ff;
    nxt_halt       = halt_ff;
    if (wr_ctrl) begin
      nxt_ctrl = reg_wdata;
    end
    if (wr_flag) begin
      // only zero is a clear; writing one leaves the flag alone
      if (!reg_wdata[`RIO_BIT_FIRST_FLG]) begin
        nxt_first_flg = 1'b0; // R22
      end
      if (!reg_wdata[`RIO_BIT_SECOND_FLG]) begin
        nxt_second_flg = 1'b0; // R22
      end
      if (!reg_wdata[`RIO_BIT_PER_FLG]) begin
        nxt_per_flg = 1'b0; // R21
      end
      // the write that clears halt still sees the inhibit forced off
      nxt_clk_inh = reg_wdata[`RIO_BIT_CLK_INH] & ~halt_ff; // R5 R20
      nxt_halt    = 1'b0;
    end
    // events placed after the clears: set wins over clear
    if (first_alarm_match && first_en) begin
      nxt_first_flg = 1'b1; // R10
    end
    if (second_alarm_match && second_en) begin
      nxt_second_flg = 1'b1; // R10
    end
    // a disabled alarm shows no pending flag
    if (!nxt_ctrl[`RIO_BIT_FIRST_EN]) begin
      nxt_first_flg = 1'b0; // R11
    end
    if (!nxt_ctrl[`RIO_BIT_SECOND_EN]) begin
      nxt_second_flg = 1'b0; // R11
    end
    if (level_mode) begin
      if (level_evt) begin
        nxt_per_flg = 1'b1; // R14
      end
    end else begin
      nxt_per_flg = pulse_low; // R11
    end
    if (osc_halt_detect) begin
      nxt_halt = 1'b1;
    end
    // halt forces the control bits; halt also means cycle is off
    if (nxt_halt) begin
      nxt_ctrl       = `RIO_CTRL_RESET; // R20 R6
      nxt_clk_inh    = 1'b0; // R20 R7
      nxt_first_flg  = 1'b0;
      nxt_second_flg = 1'b0;
      nxt_per_flg    = 1'b0;
    end
  end

  always @* begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      `RIO_OFS_CTRL: begin
        nxt_rdata = ctrl_ff;
      end
      `RIO_OFS_FLAG: begin
        nxt_rdata[`RIO_BIT_SECOND_FLG] = second_flg_ff; // R3 R9
        nxt_rdata[`RIO_BIT_FIRST_FLG]  = first_flg_ff; // R2 R9
        nxt_rdata[`RIO_BIT_PER_FLG]    = per_flg_ff; // R4 R9
        nxt_rdata[`RIO_BIT_CLK_INH]    = clk_inh_ff;
        nxt_rdata[`RIO_BIT_HALT]       = halt_ff;
      end
      default: begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  // ***********************************************
  // flip-flops
  // ***********************************************
  // reset stands for power-on: halt flag comes up set
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff       <= `RIO_CTRL_RESET; // R6
      first_flg_ff  <= 1'b0;
      second_flg_ff <= 1'b0;
      per_flg_ff    <= 1'b0;
      clk_inh_ff    <= 1'b0; // R7
      halt_ff       <= 1'b1; // R6
      osc_d_ff      <= 1'b0;
      sub_ff        <= {SW{1'b0}};
      reg_rdata     <= 8'h00;
    end else begin
      ctrl_ff       <= nxt_ctrl;
      first_flg_ff  <= nxt_first_flg;
      second_flg_ff <= nxt_second_flg;
      per_flg_ff    <= nxt_per_flg;
      clk_inh_ff    <= nxt_clk_inh;
      halt_ff       <= nxt_halt;
      osc_d_ff      <= osc_clk;
      sub_ff        <= nxt_sub;
      reg_rdata     <= nxt_rdata;
    end
  end

  // ***********************************************
  // source activity
  // ***********************************************
  assign first_act    = first_en & first_flg_ff; // R11
  assign second_act   = second_en & second_flg_ff; // R11
  // flag mirrors the periodic output in every mode
  assign periodic_act = (cyc_sel != `RIO_CYC_OFF) & per_flg_ff; // R4
  // raw oscillator, untouched by trim
  assign clock_low    = ~clk_inh_ff & ~osc_clk; // R18 R5

  rio_pin_mux #(
    .SINGLE_PIN (SINGLE_PIN)
  ) u_pin_mux (
    .ref_clk           (ref_clk),
    .rst_b             (rst_b),
    .first_act         (first_act),
    .second_act        (second_act),
    .periodic_act      (periodic_act),
    .clock_low         (clock_low),
    .route_sel         (route_sel),
    .irq_out_first_oe  (irq_out_first_oe),
    .irq_out_second_oe (irq_out_second_oe),
    .irq_out_single_oe (irq_out_single_oe),
    .osc_clock_pin_oe  (osc_clock_pin_oe)
  );

  // open-drain: data is always low, enable does the work
  assign irq_out_first_o  = 1'b0; // R23
  assign irq_out_second_o = 1'b0; // R23
  assign irq_out_single_o = 1'b0; // R23
  assign osc_clock_pin_o  = 1'b0; // R23

endmodule // rio_irq_ctl

// ### tb/rio_irq_ctl_properties.sv
// Purpose: port checks of rio_irq_ctl, two-pin variant
// Assumes: control state is rebuilt from the register write port
// Notes:   flags are taken as clear whenever control goes back to zero
`timescale 1ns/1ps
module rio_irq_ctl_properties (
  input wire       ref_clk,
  input wire       rst_b,
  input wire       osc_clk,
  input wire       tick_sec,
  input wire       first_alarm_match,
  input wire       second_alarm_match,
  input wire       osc_halt_detect,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire [7:0] reg_rdata,
  input wire       irq_out_first_o,
  input wire       irq_out_first_oe,
  input wire       irq_out_second_o,
  input wire       irq_out_second_oe,
  input wire       irq_out_single_o,
  input wire       irq_out_single_oe,
  input wire       osc_clock_pin_o,
  input wire       osc_clock_pin_oe
);
  // ****
  // mirror of control state
  // ****
  reg  [7:0] ctrl_ff;
  reg        halt_ff;
  reg        inh_ff;
  wire       quiet = ctrl_ff[7:6] == 2'h0 && ctrl_ff[2:0] == 3'h0;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= 8'h00;
      halt_ff <= 1'h1;
      inh_ff  <= 1'h0;
    end else if (osc_halt_detect) begin
      ctrl_ff <= 8'h00;
      halt_ff <= 1'h1;
      inh_ff  <= 1'h0;
    end else begin
      if (reg_wr && reg_addr == 4'hE && !halt_ff) begin
        ctrl_ff <= reg_wdata;
      end
      if (reg_wr && reg_addr == 4'hF) begin
        halt_ff <= 1'h0;
        inh_ff  <= reg_wdata[3] & ~halt_ff;
      end
    end
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  a_first_off_reset: assert property (
    $rose(rst_b) |-> !irq_out_first_oe [*3])
    else $error("pin a active right after reset");
  a_halt_reads_set: assert property (
    $rose(rst_b) && reg_addr == 4'hF |=> reg_rdata == 8'h10)
    else $error("flag register wrong after reset");
  a_unmapped_zero: assert property (
    reg_addr < 4'hE |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_first_alarm: assert property (
    first_alarm_match && ctrl_ff[7] && !reg_wr ##1 !reg_wr
    |=> irq_out_first_oe)
    else $error("first alarm did not pull pin a");
  a_second_route: assert property (
    second_alarm_match && ctrl_ff[6] && !reg_wr ##1 !reg_wr
    |=> (ctrl_ff[4] ? irq_out_second_oe : irq_out_first_oe))
    else $error("second alarm on wrong pin");
  a_level_tick: assert property (
    tick_sec && ctrl_ff[2:0] == 3'h4 && !reg_wr ##1 !reg_wr
    |=> (ctrl_ff[5] ? irq_out_second_oe : irq_out_first_oe))
    else $error("level interrupt late or on wrong pin");
  a_fixed_low: assert property (
    (ctrl_ff[2:0] == 3'h1 && !ctrl_ff[5]) [*3] |-> irq_out_first_oe)
    else $error("fixed low code not low");
  a_clock_on_b: assert property (
    !inh_ff && !osc_clk |=> irq_out_second_oe)
    else $error("clock low phase missing on pin b");
  a_clock_off: assert property (
    (inh_ff && quiet) [*3] |-> !irq_out_second_oe)
    else $error("pin b not released with clock off");
  a_quiet_a: assert property (
    quiet [*3] |-> !irq_out_first_oe)
    else $error("pin a active with all sources off");
  a_drive_low: assert property (
    !irq_out_first_o && !irq_out_second_o
    && !irq_out_single_o && !osc_clock_pin_o)
    else $error("open drain output not low");
  a_unused_pins: assert property (
    !irq_out_single_oe && !osc_clock_pin_oe)
    else $error("single-pin variant output active in two-pin build");
  c_alarm: cover property (first_alarm_match && ctrl_ff[7]);
  c_level: cover property (tick_sec && ctrl_ff[2]);
  c_halt: cover property (osc_halt_detect);
endmodule // rio_irq_ctl_properties

bind rio_irq_ctl rio_irq_ctl_properties rio_irq_ctl_properties_i (.*);

// ### tb/rio_host_model.sv
// Purpose: host cpu side: register master and pulled-up pin receiver
// Assumes: register port takes a write on the edge it sees reg_wr
// Notes:   write data is inverted once released
`timescale 1ns/1ps
module rio_host_model (
  input  wire       ref_clk,
  input  wire       irq_out_first_oe,
  input  wire       irq_out_second_oe,
  input  wire [7:0] reg_rdata,
  output reg  [3:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_wr,
  output wire       pin_a,
  output wire       pin_b
);
  // ****
  // pins and register access
  // ****
  assign pin_a = ~irq_out_first_oe;
  assign pin_b = ~irq_out_second_oe;
  initial begin
    reg_addr = 4'hF;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
  end
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(posedge ref_clk);
      #1;
      reg_wr = 1'h0;
      reg_wdata = ~d;
    end
  endtask
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      @(posedge ref_clk);
      #1;
      d = reg_rdata;
    end
  endtask
endmodule // rio_host_model

// ### tb/rio_irq_ctl_bench.sv
// Purpose: self-checking bench of rio_irq_ctl, two-pin variant
// Assumes: fast oscillator, 8 ref_clk cycles a period, keeps runs short
// Notes:   pulse-mode half periods are too long to time here
`timescale 1ns/1ps
module rio_irq_ctl_bench;
  reg        ref_clk;
  reg        rst_b;
  reg        osc_clk;
  reg  [1:0] osc_cnt;
  reg        xtal_32000;
  reg        tick_sec;
  reg  [2:0] tops;
  reg        first_alarm_match;
  reg        second_alarm_match;
  reg        osc_halt_detect;
  wire [3:0] reg_addr;
  wire [7:0] reg_wdata;
  wire       reg_wr;
  wire [7:0] reg_rdata;
  wire       first_oe;
  wire       second_oe;
  wire       single_oe;
  wire       clkpin_oe;
  wire       pin_a;
  wire       pin_b;
  integer    failures;
  integer    checks;
  integer    seed;
  integer    i;
  integer    n;
  reg  [7:0] exp_e;
  reg  [7:0] exp_f;
  reg  [7:0] v;
  rio_irq_ctl #(.SINGLE_PIN(0)) rio_irq_ctl_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .osc_clk(osc_clk),
    .xtal_32000(xtal_32000), .tick_sec(tick_sec),
    .at_minute_top(tops[0]), .at_hour_top(tops[1]),
    .at_month_top(tops[2]), .first_alarm_match(first_alarm_match),
    .second_alarm_match(second_alarm_match),
    .osc_halt_detect(osc_halt_detect), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .irq_out_first_o(), .irq_out_first_oe(first_oe),
    .irq_out_second_o(), .irq_out_second_oe(second_oe),
    .irq_out_single_o(), .irq_out_single_oe(single_oe),
    .osc_clock_pin_o(), .osc_clock_pin_oe(clkpin_oe)
  );
  rio_host_model rio_host_model_i (
    .ref_clk(ref_clk), .irq_out_first_oe(first_oe),
    .irq_out_second_oe(second_oe), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .pin_a(pin_a), .pin_b(pin_b)
  );
  // ****
  // clocks, model and tasks
  // ****
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    osc_cnt <= osc_cnt + 2'h1;
    if (osc_cnt == 2'h3) osc_clk <= #1 ~osc_clk;
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      rio_host_model_i.wr(a, d);
      if (a == 4'hE && !exp_f[4]) exp_e = d;
      if (a == 4'hF) begin
        exp_f[2:0] = exp_f[2:0] & d[2:0];
        exp_f[3] = d[3] & ~exp_f[4];
        exp_f[4] = 1'h0;
      end
    end
  endtask
  task rd(input [3:0] a, input [7:0] m);
    begin
      rio_host_model_i.rd(a, v);
      chk(v & m, (a == 4'hE ? exp_e : a == 4'hF ? exp_f : 8'h00) & m);
    end
  endtask
  task pulse(input integer k);
    begin
      @(posedge ref_clk);
      #1;
      tops = $random(seed);
      first_alarm_match = (k == 0);
      second_alarm_match = (k == 1);
      tick_sec = (k == 2);
      osc_halt_detect = (k == 3);
      @(posedge ref_clk);
      #1;
      if (k == 0 && exp_e[7]) exp_f[1] = 1'h1;
      if (k == 1 && exp_e[6]) exp_f[0] = 1'h1;
      if (k == 2 && exp_e[2] && (exp_e[1:0] == 2'h0 ||
          tops[exp_e[1:0] - 2'h1])) exp_f[2] = 1'h1;
      if (k == 3) exp_e = 8'h00;
      if (k == 3) exp_f = 8'h10;
      {first_alarm_match, second_alarm_match} = 2'h0;
      {tick_sec, osc_halt_detect} = 2'h0;
    end
  endtask
  task pins;
    reg per;
    reg pa;
    reg pb;
    begin
      repeat (3) @(posedge ref_clk);
      #1;
      per = (exp_e[2:0] == 3'h1) | (exp_e[2] & exp_f[2]);
      pa = exp_e[7] & exp_f[1] | exp_e[6] & exp_f[0] & ~exp_e[4]
           | per & ~exp_e[5];
      pb = exp_e[6] & exp_f[0] & exp_e[4] | per & exp_e[5];
      chk({7'h00, pin_a}, {7'h00, ~pa});
      if (exp_f[3]) chk({7'h00, pin_b}, {7'h00, ~pb});
      chk({6'h00, single_oe, clkpin_oe}, 8'h00);
    end
  endtask
  task count_b;
    reg last;
    begin
      n = 0;
      last = pin_b;
      repeat (40) begin
        @(posedge ref_clk);
        #1;
        if (pin_b !== last) n = n + 1;
        last = pin_b;
      end
      chk(n[7:0], 8'h0A);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  // ****
  // tests
  // ****
  initial begin
    ref_clk = 1'h0;
    rst_b = 1'h0;
    osc_clk = 1'h0;
    osc_cnt = 2'h0;
    xtal_32000 = 1'h0;
    tops = 3'h0;
    {first_alarm_match, second_alarm_match} = 2'h0;
    {tick_sec, osc_halt_detect} = 2'h0;
    failures = 0;
    checks = 0;
    seed = 32'hdbf6;
    exp_e = 8'h00;
    exp_f = 8'h10;
    repeat (20) @(posedge ref_clk);
    #1;
    rst_b = 1'h1;
    rd(4'hF, 8'hFF);
    rd(4'hE, 8'hFF);
    pins;
    count_b;
    $display("test power-on done");
    wr(4'hE, 8'hFF);
    rd(4'hE, 8'hFF);
    wr(4'h5, 8'hFF);
    rd(4'h3, 8'hFF);
    wr(4'hF, 8'h08);
    rd(4'hF, 8'hFF);
    wr(4'hF, 8'h08);
    rd(4'hF, 8'hFF);
    $display("test halt lock done");
    for (i = 0; i < 4; i = i + 1) begin
      wr(4'hE, 8'h00);
      wr(4'hE, {2'h3, i[1:0], 4'h0});
      pulse(1);
      pins;
      pulse(0);
      pins;
      rd(4'hF, 8'hFF);
      wr(4'hF, 8'h09);
      pins;
      wr(4'hF, 8'h08);
      pins;
    end
    $display("test routes done");
    for (i = 4; i < 8; i = i + 1) begin
      wr(4'hE, {2'h0, i[0], 2'h0, i[2:0]});
      repeat (3) begin
        pulse(2);
        rd(4'hF, 8'hFF);
        pins;
      end
      wr(4'hF, 8'h08);
      pins;
    end
    $display("test level done");
    wr(4'hE, 8'h01);
    pins;
    // 2 Hz on the 32.000 kHz crystal, then 1 Hz on the 32.768 kHz one
    for (i = 2; i < 4; i = i + 1) begin
      xtal_32000 = (i == 2);
      wr(4'hE, i[7:0]);
      pulse(2);
      repeat (4) @(posedge ref_clk);
      #1;
      chk({7'h00, pin_a}, 8'h01);
      repeat (30) @(posedge ref_clk);
      #1;
      chk({7'h00, pin_a}, 8'h00);
    end
    wr(4'hE, 8'h00);
    $display("test pulse done");
    wr(4'hE, 8'hC7);
    pulse(3);
    rd(4'hE, 8'hFF);
    rd(4'hF, 8'h1B);
    pins;
    count_b;
    $display("test halt done");
    end_sim;
  end
  initial begin
    #200000;
    failures = failures + 1;
    end_sim;
  end
endmodule // rio_irq_ctl_bench
